// file: rtl/cmmd_pkg.sv
// constants shared by the memory map decoder files
package cmmd_pkg;
   // internal data space
   localparam logic [7:0] IDATA_UPPER_BASE = 8'h80;
   localparam logic [7:0] BANK_AREA_END = 8'h1f;
   localparam logic [7:0] BIT_AREA_BASE = 8'h20;
   localparam logic [7:0] BIT_AREA_END = 8'h2f;
   localparam int BANK_COUNT = 4;
   localparam int BANK_SIZE = 8;
   // external data space
   localparam int XRAM_BYTES = 1024;
   localparam int XRAM_ADDR_W = 10;
   // program space
   localparam logic [15:0] FLASH_MAIN_END = 16'h3fff;
   localparam logic [15:0] FLASH_FACTORY_BASE = 16'h3e00;
   localparam logic [15:0] FLASH_EXTRA_BASE = 16'h8000;
   localparam logic [15:0] FLASH_EXTRA_END = 16'h807f;
   localparam int FLASH_SECTOR_BYTES = 512;
   localparam int FLASH_SECTOR_W = 9;
   // reset values
   localparam logic [1:0] BANK_SEL_RESET = 2'h0;
   // decode target codes
   typedef enum logic [3:0] {
      CMMD_TGT_NONE = 4'h0,
      CMMD_TGT_IRAM = 4'h1,
      CMMD_TGT_SFS = 4'h2,
      CMMD_TGT_XRAM = 4'h4,
      CMMD_TGT_FLASH = 4'h8
   } cmmd_target_t;
endpackage

// file: rtl/cmmd_flash_if.sv
// carrier between the decoder and its flash program/erase sequencer
`timescale 1ns/1ns
interface cmmd_flash_if;
   logic erase_req; // one-cycle erase request
   logic write_req; // one-cycle byte write request
   logic [15:0] addr; // program address
   logic [7:0] wdata; // byte to program
   logic busy; // sequencer busy
   logic denied; // last request blocked
   modport dec (output erase_req, write_req, addr, wdata, input busy, denied);
   modport seq (input erase_req, write_req, addr, wdata, output busy, denied);
endinterface

// file: rtl/cmmd_flash_seq.sv
// flash sector erase / byte program sequencer with factory sector lockout
`timescale 1ns/1ns
module cmmd_flash_seq #(
   parameter int OP_CYCLES = 16
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   cmmd_flash_if.seq fl,
   output logic [15:0] sector_base_o
);
   // ------------------------------------------------------------
   // sequencer state
   // ------------------------------------------------------------
   logic [15:0] cnt_reg, cnt_next; // cycles left in operation
   logic busy_reg, busy_next;
   logic denied_reg, denied_next; // sticky until next request
   logic [15:0] base_reg, base_next; // sector base for an erase, full byte address for a write
   logic req; // any request

   // next state: erase works on a whole sector, write keeps address
   always_comb begin
      req = fl.erase_req | fl.write_req;
      cnt_next = cnt_reg;
      busy_next = busy_reg;
      denied_next = denied_reg;
      base_next = base_reg;
      if (busy_reg) begin
         cnt_next = cnt_reg - 16'h0001;
         if (cnt_reg == 16'h0001) begin
            busy_next = 1'b0;
         end
      end else if (req) begin
         // requests into the factory sector are refused
         if (fl.addr >= cmmd_pkg::FLASH_FACTORY_BASE && fl.addr <= cmmd_pkg::FLASH_MAIN_END) begin
            denied_next = 1'b1;
         end else begin
            denied_next = 1'b0;
            busy_next = 1'b1;
            cnt_next = 16'(OP_CYCLES);
            // RL8 - sector aligned erase
            base_next = fl.erase_req ?
               {fl.addr[15:cmmd_pkg::FLASH_SECTOR_W], {cmmd_pkg::FLASH_SECTOR_W{1'b0}}} :
               fl.addr;
         end
      end
   end

   // registers only
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_reg <= 16'h0000;
         busy_reg <= 1'b0;
         denied_reg <= 1'b0;
         base_reg <= 16'h0000;
      end else begin
         cnt_reg <= cnt_next;
         busy_reg <= busy_next;
         denied_reg <= denied_next;
         base_reg <= base_next;
      end
   end

   assign fl.busy = busy_reg;
   assign fl.denied = denied_reg;
   assign sector_base_o = base_reg;
endmodule

// file: rtl/cmmd_decoder.sv
// memory map decoder: internal data, external data and program space
`timescale 1ns/1ns
// How it works
// RL1 - indirect upper half goes to RAM
// RL2 - direct upper half goes to special space
// RL3 - lower half same for both modes
// RL4 - low 32 bytes are four register banks
// RL5 - next 16 bytes bit addressable too
// RL6 - 1024-byte block answers across 64k
// RL7 - flash is 16k plus 128 bytes
// RL8 - in-system sector erase, 512 bytes
// RL9 - software avoids 0x3e00 to 0x3fff
// RL10 - extra 128-byte block at 0x8000
// RL11 - external block uses low ten bits
module cmmd_decoder #(
   parameter int FLASH_OP_CYCLES = 16
) (
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   // internal data access
   input wire logic [7:0] idata_addr_i,
   input wire logic idata_indirect_i,
   input wire logic idata_valid_i,
   // register bank operand
   input wire logic [1:0] bank_sel_i,
   input wire logic [2:0] reg_num_i,
   // bit access
   input wire logic [6:0] bit_addr_i,
   // external data access
   input wire logic [15:0] xdata_addr_i,
   input wire logic xdata_valid_i,
   // program access
   input wire logic [15:0] code_addr_i,
   input wire logic code_valid_i,
   // flash programming requests
   input wire logic flash_erase_i,
   input wire logic flash_write_i,
   input wire logic [7:0] flash_wdata_i,
   // decode results
   output logic [3:0] idata_target_o,
   output logic [7:0] iram_index_o,
   output logic [6:0] sfs_index_o,
   output logic [7:0] reg_index_o,
   output logic [7:0] bit_byte_index_o,
   output logic [2:0] bit_pos_o,
   output logic xram_sel_o,
   output logic [9:0] xram_index_o,
   output logic flash_main_sel_o,
   output logic flash_extra_sel_o,
   output logic [13:0] flash_index_o,
   output logic [6:0] flash_extra_index_o,
   output logic code_unmapped_o,
   output logic flash_busy_o,
   output logic flash_denied_o,
   output logic [15:0] flash_sector_o
);
   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   logic rst_s1_reg, rst_n; // two-stage release, async assert

   // synchroniser: first stage read only by second
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_s1_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_n <= rst_s1_reg;
      end
   end

   // ------------------------------------------------------------
   // internal data decode
   // ------------------------------------------------------------
   logic [3:0] it_next, it_reg; // target of internal access
   logic [7:0] iram_next, iram_reg;
   logic [6:0] sfs_next, sfs_reg;
   logic [7:0] regi_next, regi_reg; // register operand byte
   logic [7:0] bbyte_next, bbyte_reg;
   logic [2:0] bpos_next, bpos_reg;

   // register bank address: bank times eight plus register number
   function automatic logic [7:0] bank_addr(input logic [1:0] b, input logic [2:0] r);
      bank_addr = {3'h0, b, r};
   endfunction

   // combinational decode for the internal space
   always_comb begin
      it_next = cmmd_pkg::CMMD_TGT_NONE;
      iram_next = iram_reg;
      sfs_next = sfs_reg;
      if (idata_valid_i) begin
         if (idata_addr_i >= cmmd_pkg::IDATA_UPPER_BASE) begin
            if (idata_indirect_i) begin
               // RL1 - indirect reaches upper RAM
               it_next = cmmd_pkg::CMMD_TGT_IRAM;
               iram_next = idata_addr_i;
            end else begin
               // RL2 - direct reaches special space
               it_next = cmmd_pkg::CMMD_TGT_SFS;
               sfs_next = idata_addr_i[6:0];
            end
         end else begin
            // RL3 - mode does not matter here
            it_next = cmmd_pkg::CMMD_TGT_IRAM;
            iram_next = idata_addr_i;
         end
      end
      // RL4 - selected bank gives operands
      regi_next = bank_addr(bank_sel_i, reg_num_i);
      // RL5 - bit address into bytes 0x20..0x2f
      bbyte_next = cmmd_pkg::BIT_AREA_BASE + {4'h0, bit_addr_i[6:3]};
      bpos_next = bit_addr_i[2:0];
   end

   // registers for internal decode
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         it_reg <= cmmd_pkg::CMMD_TGT_NONE;
         iram_reg <= 8'h00;
         sfs_reg <= 7'h00;
         regi_reg <= 8'h00;
         bbyte_reg <= 8'h00;
         bpos_reg <= 3'h0;
      end else begin
         it_reg <= it_next;
         iram_reg <= iram_next;
         sfs_reg <= sfs_next;
         regi_reg <= regi_next;
         bbyte_reg <= bbyte_next;
         bpos_reg <= bpos_next;
      end
   end

   // ------------------------------------------------------------
   // external data decode
   // ------------------------------------------------------------
   logic xsel_next, xsel_reg;
   logic [9:0] xidx_next, xidx_reg;

   // every address hits the block, it repeats every 1k
   always_comb begin
      // RL6 - no address misses the block
      xsel_next = xdata_valid_i;
      // RL11 - upper six bits ignored
      xidx_next = xdata_addr_i[cmmd_pkg::XRAM_ADDR_W-1:0];
   end

   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         xsel_reg <= 1'b0;
         xidx_reg <= 10'h000;
      end else begin
         xsel_reg <= xsel_next;
         xidx_reg <= xidx_next;
      end
   end

   // ------------------------------------------------------------
   // program space decode
   // ------------------------------------------------------------
   logic fm_next, fm_reg, fx_next, fx_reg, un_next, un_reg;
   logic [13:0] fi_next, fi_reg;
   logic [6:0] fxi_next, fxi_reg;

   // main array below 0x4000, extra block at 0x8000, rest unmapped
   always_comb begin
      fm_next = 1'b0;
      fx_next = 1'b0;
      un_next = 1'b0;
      fi_next = code_addr_i[13:0];
      fxi_next = code_addr_i[6:0];
      if (code_valid_i) begin
         // RL7 - 16k main array
         if (code_addr_i <= cmmd_pkg::FLASH_MAIN_END) begin
            fm_next = 1'b1;
         // RL10 - extra block decode
         end else if (code_addr_i >= cmmd_pkg::FLASH_EXTRA_BASE &&
                      code_addr_i <= cmmd_pkg::FLASH_EXTRA_END) begin
            fx_next = 1'b1;
         end else begin
            un_next = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         fm_reg <= 1'b0;
         fx_reg <= 1'b0;
         un_reg <= 1'b0;
         fi_reg <= 14'h0000;
         fxi_reg <= 7'h00;
      end else begin
         fm_reg <= fm_next;
         fx_reg <= fx_next;
         un_reg <= un_next;
         fi_reg <= fi_next;
         fxi_reg <= fxi_next;
      end
   end

   // ------------------------------------------------------------
   // flash programming
   // ------------------------------------------------------------
   cmmd_flash_if fl();
   assign fl.erase_req = flash_erase_i;
   assign fl.write_req = flash_write_i;
   assign fl.addr = code_addr_i;
   assign fl.wdata = flash_wdata_i;

   // RL9 - factory sector refused as a guard
   cmmd_flash_seq #(.OP_CYCLES(FLASH_OP_CYCLES)) u_seq (
      .clk_i(clk_sys_i),
      .rst_n_i(rst_n),
      .fl(fl),
      .sector_base_o(flash_sector_o)
   );

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign idata_target_o = it_reg;
   assign iram_index_o = iram_reg;
   assign sfs_index_o = sfs_reg;
   assign reg_index_o = regi_reg;
   assign bit_byte_index_o = bbyte_reg;
   assign bit_pos_o = bpos_reg;
   assign xram_sel_o = xsel_reg;
   assign xram_index_o = xidx_reg;
   assign flash_main_sel_o = fm_reg;
   assign flash_extra_sel_o = fx_reg;
   assign flash_index_o = fi_reg;
   assign flash_extra_index_o = fxi_reg;
   assign code_unmapped_o = un_reg;
   assign flash_busy_o = fl.busy;
   assign flash_denied_o = fl.denied;
endmodule

// file: sim/cmmd_properties.sv
// port-level assertions for the memory map decoder
`timescale 1ns/1ns
module cmmd_properties (
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic [7:0] idata_addr_i,
   input wire logic idata_indirect_i,
   input wire logic idata_valid_i,
   input wire logic [1:0] bank_sel_i,
   input wire logic [2:0] reg_num_i,
   input wire logic [6:0] bit_addr_i,
   input wire logic [15:0] xdata_addr_i,
   input wire logic xdata_valid_i,
   input wire logic [15:0] code_addr_i,
   input wire logic code_valid_i,
   input wire logic flash_erase_i,
   input wire logic [3:0] idata_target_o,
   input wire logic [7:0] iram_index_o,
   input wire logic [6:0] sfs_index_o,
   input wire logic [7:0] reg_index_o,
   input wire logic [7:0] bit_byte_index_o,
   input wire logic [2:0] bit_pos_o,
   input wire logic xram_sel_o,
   input wire logic [9:0] xram_index_o,
   input wire logic flash_main_sel_o,
   input wire logic flash_extra_sel_o,
   input wire logic [13:0] flash_index_o,
   input wire logic [6:0] flash_extra_index_o,
   input wire logic flash_busy_o,
   input wire logic [15:0] flash_sector_o
);
   // ------------------------------
   // wait out the two-flop reset release
   // ------------------------------
   logic [1:0] live_reg; // edges seen since release
   logic [1:0] live_next;
   always_comb live_next = {live_reg[0], 1'b1};
   always_ff @(posedge clk_sys_i or negedge reset_n_i)
      if (!reset_n_i) live_reg <= 2'h0;
      else live_reg <= live_next;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);
   AST_SFS: assert property (live_reg[1] && idata_valid_i && !idata_indirect_i
      && idata_addr_i[7] |=> idata_target_o == 4'h2 && sfs_index_o == $past(idata_addr_i[6:0]))
      else $error("bad sfs");
   AST_RAM: assert property (live_reg[1] && idata_valid_i
      && (idata_indirect_i || !idata_addr_i[7])
      |=> idata_target_o == 4'h1 && iram_index_o == $past(idata_addr_i)) else $error("bad ram");
   AST_BANK: assert property (live_reg[1]
      |=> reg_index_o == {3'h0, $past(bank_sel_i), $past(reg_num_i)}) else $error("bad bank");
   AST_BIT: assert property (live_reg[1]
      |=> bit_byte_index_o == {4'h2, $past(bit_addr_i[6:3])} && bit_pos_o == $past(bit_addr_i[2:0]))
      else $error("bad bit");
   AST_XRAM: assert property (live_reg[1] && xdata_valid_i
      |=> xram_sel_o && xram_index_o == $past(xdata_addr_i[9:0])) else $error("bad xram");
   AST_MAIN: assert property (live_reg[1] && code_valid_i && code_addr_i <= 16'h3fff
      |=> flash_main_sel_o && !flash_extra_sel_o && flash_index_o == $past(code_addr_i[13:0]))
      else $error("bad main flash");
   AST_EXTRA: assert property (live_reg[1] && code_valid_i && code_addr_i[15:7] == 9'h100
      |=> flash_extra_sel_o && !flash_main_sel_o && flash_extra_index_o == $past(code_addr_i[6:0]))
      else $error("bad extra flash");
   AST_ERASE: assert property (live_reg[1] && !flash_busy_o && flash_erase_i
      && code_addr_i < 16'h3e00
      |=> flash_busy_o && flash_sector_o == {$past(code_addr_i[15:9]), 9'h000})
      else $error("bad erase");
endmodule

// file: sim/cmmd_core_model.sv
// core side model: program fetches and flash requests
`timescale 1ns/1ns
module cmmd_core_model (
   input wire logic clk_i,
   input wire logic busy_i,
   output logic [15:0] code_addr_o = 16'h0000,
   output logic code_valid_o = 1'b0,
   output logic erase_o = 1'b0,
   output logic write_o = 1'b0,
   output logic [7:0] wdata_o = 8'h00
);
   // one fetch address, held for one sample
   task automatic fetch(input logic [15:0] a, input logic v);
      code_addr_o = a;
      code_valid_o = v;
   endtask
   // one erase or byte write, only once busy is low
   task automatic prog(input logic er, input logic [15:0] a, input logic misuse);
      int n;
      n = 0;
      // let one edge pass so strobes never change twice in one step
      @(negedge clk_i);
      while (busy_i !== 1'b0 && n < 100) begin
         n++;
         @(negedge clk_i);
      end
      // factory sector kept clear unless misuse ordered
      code_addr_o = (!misuse && a[15:9] == 7'h1f) ? 16'h0000 : a;
      code_valid_o = 1'b0;
      erase_o = er;
      write_o = !er;
      wdata_o = a[7:0] ^ 8'h5a;
      @(negedge clk_i);
      erase_o = 1'b0;
      write_o = 1'b0;
      wdata_o = ~wdata_o;
   endtask
endmodule

// file: sim/tb.sv
// self-checking bench for the memory map decoder
`timescale 1ns/1ns
module tb;
   localparam int OPC = 4; // short flash operation keeps the run brief
   localparam logic [7:0] CIA [8] = '{8'h00, 8'h1f, 8'h20, 8'h2f, 8'h7f, 8'h80, 8'hff, 8'hc0};
   localparam logic [15:0] CXA [8] = '{16'h0, 16'h3ff, 16'h400, 16'hffff, 16'h8000, 16'hfc00,
      16'h7bff, 16'h1234};
   localparam logic [15:0] CCA [8] = '{16'h0, 16'h8080, 16'h3e00, 16'h3fff, 16'h4000, 16'h7fff,
      16'h8000, 16'h807f};
   localparam logic [15:0] FAD [5] = '{16'h1234, 16'h3fff, 16'h0abc, 16'h3e00, 16'h3dff};
   localparam logic FER [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
   logic clk_sys_i = 1'b0, reset_n_i = 1'b0, idata_indirect_i = 1'b0, idata_valid_i = 1'b0;
   logic xdata_valid_i = 1'b0, code_valid_i, flash_erase_i, flash_write_i, xram_sel_o;
   logic flash_main_sel_o, flash_extra_sel_o, code_unmapped_o, flash_busy_o, flash_denied_o;
   logic [1:0] bank_sel_i = 2'h0;
   logic [2:0] reg_num_i = 3'h0, bit_pos_o;
   logic [3:0] idata_target_o;
   logic [6:0] bit_addr_i = 7'h00, sfs_index_o, flash_extra_index_o;
   logic [7:0] idata_addr_i = 8'h00, iram_index_o, reg_index_o, bit_byte_index_o, flash_wdata_i;
   logic [9:0] xram_index_o;
   logic [13:0] flash_index_o;
   logic [15:0] xdata_addr_i = 16'h0000, code_addr_i, flash_sector_o;
   logic [31:0] seed = 32'hc569; // xorshift state, fixed start
   int n_errors = 0;
   int samples_checked = 0;
   int cyc = 0;
   cmmd_decoder #(.FLASH_OP_CYCLES(OPC)) DUT (
      .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .idata_addr_i(idata_addr_i),
      .idata_indirect_i(idata_indirect_i), .idata_valid_i(idata_valid_i),
      .bank_sel_i(bank_sel_i), .reg_num_i(reg_num_i), .bit_addr_i(bit_addr_i),
      .xdata_addr_i(xdata_addr_i), .xdata_valid_i(xdata_valid_i), .code_addr_i(code_addr_i),
      .code_valid_i(code_valid_i), .flash_erase_i(flash_erase_i), .flash_write_i(flash_write_i),
      .flash_wdata_i(flash_wdata_i), .idata_target_o(idata_target_o),
      .iram_index_o(iram_index_o), .sfs_index_o(sfs_index_o), .reg_index_o(reg_index_o),
      .bit_byte_index_o(bit_byte_index_o), .bit_pos_o(bit_pos_o), .xram_sel_o(xram_sel_o),
      .xram_index_o(xram_index_o), .flash_main_sel_o(flash_main_sel_o),
      .flash_extra_sel_o(flash_extra_sel_o), .flash_index_o(flash_index_o),
      .flash_extra_index_o(flash_extra_index_o), .code_unmapped_o(code_unmapped_o),
      .flash_busy_o(flash_busy_o), .flash_denied_o(flash_denied_o),
      .flash_sector_o(flash_sector_o)
   );
   cmmd_core_model core (.clk_i(clk_sys_i), .busy_i(flash_busy_o), .code_addr_o(code_addr_i),
      .code_valid_o(code_valid_i), .erase_o(flash_erase_i), .write_o(flash_write_i),
      .wdata_o(flash_wdata_i));
   initial forever #25 clk_sys_i = ~clk_sys_i;
   // hang guard, far above the planned run
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 2000) begin
         n_errors++;
         end_of_test();
      end
   end
   function automatic logic [31:0] xs(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   function automatic logic [15:0] exp_tgt(input logic [7:0] a, input logic ind, input logic v);
      return !v ? 16'h0 : (a[7] && !ind) ? 16'h2 : 16'h1;
   endfunction
   // selects as {unmapped, extra, main}
   function automatic logic [15:0] exp_code(input logic [15:0] a, input logic v);
      logic m, x;
      m = v && a <= 16'h3fff;
      x = v && a[15:7] == 9'h100;
      return {13'h0, v && !m && !x, x, m};
   endfunction
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic end_of_test();
      $display("mismatches %0d, comparisons %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      logic [15:0] t;
      int n;
      repeat (8) @(negedge clk_sys_i);
      reset_n_i = 1'b1;
      repeat (2) @(negedge clk_sys_i);
      // corners first, then random traffic, back to back
      for (int i = 0; i < 300; i++) begin
         seed = xs(seed);
         idata_addr_i = i < 8 ? CIA[i] : seed[7:0];
         idata_indirect_i = i < 8 ? i[0] : seed[8];
         idata_valid_i = i < 8 || seed[9] || seed[10];
         bank_sel_i = seed[12:11];
         reg_num_i = seed[15:13];
         bit_addr_i = seed[22:16];
         xdata_addr_i = i < 8 ? CXA[i] : seed[31:16];
         xdata_valid_i = i < 8 || seed[23];
         seed = xs(seed);
         core.fetch(i < 8 ? CCA[i] : seed[1:0] == 2'h0 ? {8'h80, seed[31:24]} : seed[31:16],
            i < 8 || seed[2]);
         @(negedge clk_sys_i);
         t = exp_tgt(idata_addr_i, idata_indirect_i, idata_valid_i);
         chk("target", t, 16'(idata_target_o));
         if (t == 16'h1) chk("iram", 16'(idata_addr_i), 16'(iram_index_o));
         if (t == 16'h2) chk("sfs", 16'(idata_addr_i[6:0]), 16'(sfs_index_o));
         chk("reg", {11'h0, bank_sel_i, reg_num_i}, 16'(reg_index_o));
         chk("bitbyte", 16'h20 + 16'(bit_addr_i[6:3]), 16'(bit_byte_index_o));
         chk("bitpos", 16'(bit_addr_i[2:0]), 16'(bit_pos_o));
         chk("xsel", 16'(xdata_valid_i), 16'(xram_sel_o));
         if (xdata_valid_i) chk("xidx", 16'(xdata_addr_i[9:0]), 16'(xram_index_o));
         t = exp_code(code_addr_i, code_valid_i);
         chk("csel", t, {13'h0, code_unmapped_o, flash_extra_sel_o, flash_main_sel_o});
         if (t[0]) chk("fidx", 16'(code_addr_i[13:0]), 16'(flash_index_o));
         if (t[1]) chk("xfidx", 16'(code_addr_i[6:0]), 16'(flash_extra_index_o));
      end
      core.fetch(16'h0000, 1'b0);
      // accepted and refused flash requests, interleaved
      for (int k = 0; k < 5; k++) begin
         core.prog(FER[k], FAD[k], 1'b1);
         t = 16'(FAD[k][15:9] != 7'h1f);
         chk("busy", t, 16'(flash_busy_o));
         chk("denied", 16'(!t[0]), 16'(flash_denied_o));
         if (t[0]) begin
            chk("sector", FER[k] ? {FAD[k][15:9], 9'h0} : FAD[k], flash_sector_o);
            n = 0;
            while (flash_busy_o === 1'b1 && n < 50) begin
               n++;
               @(negedge clk_sys_i);
            end
            chk("busylen", 16'(OPC), 16'(n));
         end
      end
      end_of_test();
   end
endmodule
bind cmmd_decoder cmmd_properties u_props (
   .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .idata_addr_i(idata_addr_i),
   .idata_indirect_i(idata_indirect_i), .idata_valid_i(idata_valid_i),
   .bank_sel_i(bank_sel_i), .reg_num_i(reg_num_i), .bit_addr_i(bit_addr_i),
   .xdata_addr_i(xdata_addr_i), .xdata_valid_i(xdata_valid_i), .code_addr_i(code_addr_i),
   .code_valid_i(code_valid_i), .flash_erase_i(flash_erase_i),
   .idata_target_o(idata_target_o), .iram_index_o(iram_index_o), .sfs_index_o(sfs_index_o),
   .reg_index_o(reg_index_o), .bit_byte_index_o(bit_byte_index_o), .bit_pos_o(bit_pos_o),
   .xram_sel_o(xram_sel_o), .xram_index_o(xram_index_o),
   .flash_main_sel_o(flash_main_sel_o), .flash_extra_sel_o(flash_extra_sel_o),
   .flash_index_o(flash_index_o), .flash_extra_index_o(flash_extra_index_o),
   .flash_busy_o(flash_busy_o), .flash_sector_o(flash_sector_o)
);
